// ### rtl/acr_pkg.sv
package acr_pkg;
	// Register addresses on the plain register port
	localparam logic [7:0] ADDR_RESULT_LOW  = 8'h78;
	localparam logic [7:0] ADDR_RESULT_HIGH = 8'h79;
	localparam logic [7:0] ADDR_CTRL        = 8'h7A;
	localparam logic [7:0] ADDR_SELECT      = 8'h7C;

	// Reset values
	localparam logic [7:0] CTRL_RESET   = 8'h00;
	localparam logic [7:0] SELECT_RESET = 8'h00;

	// Control and status field positions
	localparam int CTRL_ENABLE_BIT = 7;
	localparam int CTRL_START_BIT  = 6;
	localparam int CTRL_AUTO_BIT   = 5;
	localparam int CTRL_FLAG_BIT   = 4;
	localparam int CTRL_IRQ_BIT    = 3;
	localparam int CTRL_PRESC_LSB  = 0;

	// Input and reference select field positions
	localparam int SEL_REF_LSB   = 6;
	localparam int SEL_LEFT_BIT  = 5;
	localparam int SEL_CHAN_LSB  = 0;

	// Reference encodings
	localparam logic [1:0] REF_EXTERNAL = 2'h0;
	localparam logic [1:0] REF_SUPPLY   = 2'h1;
	localparam logic [1:0] REF_RESERVED = 2'h2;
	localparam logic [1:0] REF_INTERNAL = 2'h3;

	// Channel encodings with special meaning
	localparam logic [4:0] CHAN_BANDGAP = 5'h1E;
	localparam logic [4:0] CHAN_GROUND  = 5'h1F;

	// Conversion lengths in converter clocks
	localparam logic [4:0] FIRST_CONV_CLOCKS  = 5'h19;
	localparam logic [4:0] NORMAL_CONV_CLOCKS = 5'h0D;

	// Result code limits
	localparam int          CODE_W   = 11;
	localparam logic [9:0]  SE_MAX   = 10'h3FF;
	localparam logic [9:0]  DIFF_MAX = 10'h1FF;
	localparam logic [9:0]  DIFF_MIN = 10'h200;

	// Conversion sequencer states, one-hot
	typedef enum logic [2:0] {
		ST_IDLE = 3'h1,
		ST_RUN  = 3'h2,
		ST_POST = 3'h4
	} acr_state_t;
endpackage

// ### rtl/acr_top.sv
`timescale 1ns/10ps
module acr_top (
	input  wire logic                      mclk,
	input  wire logic                      rst,
	input  wire logic [7:0]                addr,
	input  wire logic [7:0]                wdata,
	input  wire logic                      wr,
	input  wire logic                      rd,
	output logic      [7:0]                rdata,
	input  wire logic                      irq_ack,
	output logic                           irq_request,
	input  wire logic [acr_pkg::CODE_W-1:0] core_code,
	output logic                           core_power,
	output logic                           core_run,
	output logic                           core_first,
	output logic                           core_sample,
	output logic      [1:0]                core_ref,
	output logic      [4:0]                core_channel,
	output logic                           core_diff
);
	import acr_pkg::*;

	// Control and status fields
	logic             enable;
	logic             auto_trig;
	logic             irq_en;
	logic             done_flag;
	logic [2:0]       presc;
	// Select register fields
	logic [1:0]       ref_field;
	logic             left_align;
	logic [4:0]       chan_field;
	// Sequencer
	acr_state_t       state;
	logic             first_pending;
	logic [4:0]       conv_len;
	logic [4:0]       tick_cnt;
	logic [6:0]       div_cnt;
	logic             tick;
	logic             busy;
	// Result storage
	logic [9:0]       raw;
	logic             lock;
	// Decoded strobes
	logic             wr_ctrl;
	logic             wr_sel;
	logic             rd_low;
	logic             rd_high;
	logic             start_req;
	logic             abort;
	logic             finish;

	// Differential when top bit set, except bandgap and ground
	function automatic logic chan_is_diff(input logic [4:0] ch);
		return ch[4] && (ch != CHAN_BANDGAP) && (ch != CHAN_GROUND);
	endfunction
	// Divider mask; selections 0 and 1 both divide by two
	function automatic logic [6:0] presc_mask(input logic [2:0] sel);
		case (sel)
			3'h0, 3'h1: return 7'h01;
			3'h2:       return 7'h03;
			3'h3:       return 7'h07;
			3'h4:       return 7'h0F;
			3'h5:       return 7'h1F;
			3'h6:       return 7'h3F;
			default:    return 7'h7F;
		endcase
	endfunction
	// Clamp the raw core value into the 10-bit encoding
	function automatic logic [9:0] fmt(input logic [CODE_W-1:0] c,
			input logic diff);
		if (diff && ($signed(c) > $signed(11'h1FF)))
			return DIFF_MAX;
		if (diff && ($signed(c) < $signed(11'h600)))
			return DIFF_MIN;
		if (!diff && c[10])
			return SE_MAX;
		return c[9:0];
	endfunction
	// Byte views of the stored result
	function automatic logic [7:0] low_view(input logic [9:0] r,
			input logic left);
		return left ? {r[1:0], 6'h00} : r[7:0];
	endfunction
	function automatic logic [7:0] high_view(input logic [9:0] r,
			input logic left);
		return left ? r[9:2] : {6'h00, r[9:8]};
	endfunction
	// Address decode of the strobes
	assign wr_ctrl = wr && (addr == ADDR_CTRL);
	assign wr_sel  = wr && (addr == ADDR_SELECT);
	assign rd_low  = rd && (addr == ADDR_RESULT_LOW);
	assign rd_high = rd && (addr == ADDR_RESULT_HIGH);
	// Start only from idle with enable set in the same write
	assign start_req = wr_ctrl && wdata[CTRL_START_BIT] &&
		wdata[CTRL_ENABLE_BIT] && (state == ST_IDLE);
	assign abort  = (state == ST_RUN) && wr_ctrl &&
		!wdata[CTRL_ENABLE_BIT];
	assign tick   = (state == ST_RUN) &&
		((div_cnt & presc_mask(presc)) == presc_mask(presc));
	assign finish = tick && (tick_cnt == 5'(conv_len - 5'h01)) &&
		!abort;
	assign busy   = (state != ST_IDLE);
	assign core_sample = finish;
	assign core_run    = (state == ST_RUN);
	assign core_power  = enable;
	assign irq_request = done_flag && irq_en;
	// Control fields; reset clears them all
	always_ff @(posedge mclk) begin
		if (rst) begin
			enable    <= CTRL_RESET[CTRL_ENABLE_BIT];
			auto_trig <= CTRL_RESET[CTRL_AUTO_BIT];
			irq_en    <= CTRL_RESET[CTRL_IRQ_BIT];
			presc     <= CTRL_RESET[CTRL_PRESC_LSB +: 3];
		end else if (wr_ctrl) begin
			enable    <= wdata[CTRL_ENABLE_BIT];
			auto_trig <= wdata[CTRL_AUTO_BIT];
			irq_en    <= wdata[CTRL_IRQ_BIT];
			presc     <= wdata[CTRL_PRESC_LSB +: 3];
		end
	end
	// Select register; stored as written, reserved code too
	always_ff @(posedge mclk) begin
		if (rst) begin
			ref_field  <= SELECT_RESET[SEL_REF_LSB +: 2];
			left_align <= SELECT_RESET[SEL_LEFT_BIT];
			chan_field <= SELECT_RESET[SEL_CHAN_LSB +: 5];
		end else if (wr_sel) begin
			ref_field  <= wdata[SEL_REF_LSB +: 2];
			left_align <= wdata[SEL_LEFT_BIT];
			chan_field <= wdata[SEL_CHAN_LSB +: 5];
		end
	end
	// Sequencer; abort beats a finish in the same cycle
	always_ff @(posedge mclk) begin
		if (rst) begin
			state <= ST_IDLE;
		end else begin
			case (state)
				ST_IDLE: begin
					if (start_req)
						state <= ST_RUN;
				end
				ST_RUN: begin
					if (abort)
						state <= ST_IDLE;
					else if (finish)
						state <= ST_POST;
				end
				ST_POST: state <= ST_IDLE;
				default: state <= ST_IDLE;
			endcase
		end
	end
	// First conversion after enabling runs long for core init
	always_ff @(posedge mclk) begin
		if (rst) begin
			first_pending <= 1'b0;
		end else if (start_req) begin
			first_pending <= 1'b0;
		end else if (wr_ctrl && wdata[CTRL_ENABLE_BIT] && !enable) begin
			first_pending <= 1'b1;
		end
	end
	// Length latched at start
	always_ff @(posedge mclk) begin
		if (rst) begin
			conv_len   <= NORMAL_CONV_CLOCKS;
			core_first <= 1'b0;
		end else if (start_req) begin
			conv_len   <= (first_pending || !enable) ?
				FIRST_CONV_CLOCKS : NORMAL_CONV_CLOCKS;
			core_first <= first_pending || !enable;
		end
	end
	// Prescaler restarts at each start for a fixed phase
	always_ff @(posedge mclk) begin
		if (rst || start_req || !enable)
			div_cnt <= 7'h00;
		else
			div_cnt <= 7'(div_cnt + 7'h01);
	end
	// Converter clocks elapsed in this conversion
	always_ff @(posedge mclk) begin
		if (rst || start_req)
			tick_cnt <= 5'h00;
		else if (tick)
			tick_cnt <= 5'(tick_cnt + 5'h01);
	end
	// Selection follows the register only while idle
	always_ff @(posedge mclk) begin
		if (rst) begin
			core_ref     <= REF_EXTERNAL;
			core_channel <= 5'h00;
			core_diff    <= 1'b0;
		end else if (state == ST_IDLE) begin
			// Reserved code must not drive a real switch
			core_ref     <= (ref_field == REF_RESERVED) ?
				REF_EXTERNAL : ref_field;
			core_channel <= chan_field;
			core_diff    <= chan_is_diff(chan_field);
		end
	end
	// Result capture; discarded while the pair is locked
	always_ff @(posedge mclk) begin
		if (rst)
			raw <= 10'h000;
		else if (finish && !lock)
			raw <= fmt(core_code, core_diff);
	end
	// Low read locks, high read releases
	always_ff @(posedge mclk) begin
		if (rst)
			lock <= 1'b0;
		else if (rd_high)
			lock <= 1'b0;
		else if (rd_low)
			lock <= 1'b1;
	end
	// Completion flag; a set beats a clear in the same cycle
	always_ff @(posedge mclk) begin
		if (rst)
			done_flag <= 1'b0;
		else if (state == ST_POST)
			done_flag <= 1'b1;
		else if (irq_ack || (wr_ctrl && wdata[CTRL_FLAG_BIT]))
			done_flag <= 1'b0;
	end
	// Read data valid only in the cycle after the strobe
	always_ff @(posedge mclk) begin
		if (rst || !rd) begin
			rdata <= 8'h00;
		end else begin
			case (addr)
				ADDR_RESULT_LOW:
					rdata <= low_view(raw, left_align);
				ADDR_RESULT_HIGH:
					rdata <= high_view(raw, left_align);
				ADDR_CTRL:
					rdata <= {enable, busy, auto_trig, done_flag,
						irq_en, presc};
				ADDR_SELECT:
					rdata <= {ref_field, left_align, chan_field};
				default:
					rdata <= 8'h00;
			endcase
		end
	end
	property p_flag_after_result;
		@(posedge mclk) disable iff (rst)
		finish && !lock |=> raw == fmt($past(core_code), core_diff)
			##1 done_flag && !busy;
	endproperty
	a_flag_after_result: assert property (p_flag_after_result)
		else $error("flag not one cycle after result");
	property p_abort;
		@(posedge mclk) disable iff (rst)
		abort |=> !busy && $stable(raw) ##1 !$rose(done_flag);
	endproperty
	a_abort: assert property (p_abort)
		else $error("abort updated result or flag");
	property p_lock_hold;
		@(posedge mclk) disable iff (rst)
		lock && !rd_high |=> $stable(raw);
	endproperty
	a_lock_hold: assert property (p_lock_hold)
		else $error("locked result changed");
	property p_sel_stable;
		@(posedge mclk) disable iff (rst)
		state == ST_RUN |=> $stable(core_ref) && $stable(core_channel);
	endproperty
	a_sel_stable: assert property (p_sel_stable)
		else $error("selection changed mid-conversion");
	property p_len;
		@(posedge mclk) disable iff (rst)
		finish |-> conv_len == (core_first ?
			FIRST_CONV_CLOCKS : NORMAL_CONV_CLOCKS);
	endproperty
	a_len: assert property (p_len)
		else $error("wrong conversion length");
	property p_align;
		@(posedge mclk) disable iff (rst)
		rd_low && left_align |=> rdata == {$past(raw[1:0]), 6'h00};
	endproperty
	a_align: assert property (p_align)
		else $error("left aligned low byte wrong");
	property p_diff_sat;
		@(posedge mclk) disable iff (rst)
		finish && !lock && core_diff && core_code == 11'h200
			|=> raw == DIFF_MAX;
	endproperty
	a_diff_sat: assert property (p_diff_sat)
		else $error("differential full scale not saturated");
	property p_se_ground;
		@(posedge mclk) disable iff (rst)
		finish && !lock && !core_diff && core_code == 11'h000
			|=> raw == 10'h000;
	endproperty
	a_se_ground: assert property (p_se_ground)
		else $error("ground did not read zero");
	property p_no_reserved;
		@(posedge mclk) disable iff (rst)
		core_ref != REF_RESERVED;
	endproperty
	a_no_reserved: assert property (p_no_reserved)
		else $error("reserved reference driven to core");
	property p_flag_clear;
		@(posedge mclk) disable iff (rst)
		wr_ctrl && wdata[CTRL_FLAG_BIT] && state != ST_POST
			|=> !done_flag;
	endproperty
	a_flag_clear: assert property (p_flag_clear)
		else $error("flag not cleared by write of one");
endmodule

// ### dv/acr_core_model.sv
`timescale 1ns/10ps
// Converter core stand-in: answers the level set by the bench
module acr_core_model (
	input  wire logic        core_sample,
	input  wire logic [10:0] level,
	output logic      [10:0] core_code
);
	// Code is only valid in the sample cycle; elsewhere the inverse is
	// shown so a design that samples late reads garbage, not the answer
	assign core_code = core_sample ? level : ~level;
endmodule

// ### dv/testbench.sv
`timescale 1ns/10ps
module testbench;
	import acr_pkg::*;
	logic        mclk, rst, wr, rd, irq_ack;  // Clock, reset, strobes
	logic [7:0]  addr, wdata, rdata, d, lo, hi, sel;
	logic        irq_request, core_power, core_run, core_first;
	logic        core_sample, core_diff;
	logic [1:0]  core_ref;
	logic [4:0]  core_channel;
	logic [10:0] core_code, level;            // Raw core answer
	logic [15:0] exp16;                       // Expected {high, low}
	int          n_errors, checks, i, k, ch, rf;
	int          cyc = 0, conv_cyc = 0;       // Start-to-sample cycles
	logic        df;                          // Channel is differential
	int unsigned seed = 69323;
	// Cases: channel, reference, raw; ref 3 only with pin undriven
	int          chan_t[6] = '{3, 31, 9, 16, 27, 28};
	int          ref_t[6]  = '{1, 0, 2, 3, 1, 3};
	int          lvl_t[6]  = '{1024, 0, 0, 512, 2047, 1448};

	acr_top acr_top_inst (.mclk(mclk), .rst(rst), .addr(addr),
		.wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
		.irq_ack(irq_ack), .irq_request(irq_request),
		.core_code(core_code), .core_power(core_power),
		.core_run(core_run), .core_first(core_first),
		.core_sample(core_sample), .core_ref(core_ref),
		.core_channel(core_channel), .core_diff(core_diff));
	acr_core_model acr_core_model_inst (.core_sample(core_sample),
		.level(level), .core_code(core_code));

	// Free-running system clock
	initial begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end

	// Cycles from an accepted start write to the end-of-conversion pulse,
	// looked at mid-cycle where the design's outputs have settled
	always @(negedge mclk) begin
		if (wr && addr == ADDR_CTRL && wdata[6] && wdata[7])
			cyc <= 0;
		else
			cyc <= cyc + 1;
		if (core_sample)
			conv_cyc <= cyc + 1;
	end

	function int unsigned xrand();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	// Ideal code: clamp single-ended or signed differential raw value
	function logic [15:0] expect_pair(bit df, int r, bit l);
		int s;
		logic [9:0] c;
		s = (df && r >= 1024) ? r - 2048 : r;
		if (df)
			s = (s > 511) ? 511 : ((s < -512) ? -512 : s);
		else
			s = (s > 1023) ? 1023 : s;
		c = s[9:0];
		return l ? {c[9:2], c[1:0], 6'h00} : {6'h00, c[9:8], c[7:0]};
	endfunction

	task check(input logic [7:0] seen, input logic [7:0] exp);
		checks++;
		if (seen !== exp) begin
			$display("Error t=%0t seen %h expected %h", $time, seen, exp);
			n_errors++;
		end
	endtask

	task reg_wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge mclk);
		addr  <= a;
		wdata <= v;
		wr    <= 1'b1;
		@(posedge mclk);
		wr    <= 1'b0;
	endtask

	// Read data stands only in the cycle after the strobe
	task reg_rd(input logic [7:0] a, output logic [7:0] v);
		@(posedge mclk);
		addr <= a;
		rd   <= 1'b1;
		@(posedge mclk);
		rd   <= 1'b0;
		#1 v = rdata;
	endtask

	// Poll status until the flag shows, bounded
	task wait_done();
		k = 0;
		do begin
			reg_rd(ADDR_CTRL, d);
			k++;
		end while (!d[4] && k < 100);
	endtask

	task read_pair(input logic [15:0] e);
		reg_rd(ADDR_RESULT_LOW, lo);
		reg_rd(ADDR_RESULT_HIGH, hi);
		check(lo, e[7:0]);
		check(hi, e[15:8]);
	endtask

	task stop_test();
		$display("errors %0d, comparisons %0d", n_errors, checks);
		if (n_errors == 0 && checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// Watchdog well beyond the expected run
	initial begin
		#80000;
		n_errors++;
		stop_test();
	end

	initial begin
		{rst, wr, rd, irq_ack, addr, wdata} = {4'h8, 16'h0000};
		level = 11'h000;
		repeat (4) @(posedge mclk);
		rst <= 1'b0;
		// Reset values and an unmapped place
		reg_rd(ADDR_CTRL, d);
		check(d, CTRL_RESET);
		reg_rd(ADDR_SELECT, d);
		check(d, SELECT_RESET);
		reg_rd(8'h50, d);
		check(d, 8'h00);
		sel = 8'(xrand());
		reg_wr(ADDR_SELECT, sel);
		reg_rd(ADDR_SELECT, d);
		check(d, sel);
		chan_t[2] = xrand() % 8;
		lvl_t[2] = xrand() % 1024;
		// Every encoding class except the bandgap channel, both alignments, both flag clears
		for (i = 0; i < 6; i++) begin
			ch = chan_t[i];
			rf = ref_t[i];
			df = ch >= 16 && ch <= 29;
			sel = {rf[1:0], i[0], ch[4:0]};
			level <= 11'(lvl_t[i]);
			reg_wr(ADDR_SELECT, sel);
			reg_wr(ADDR_CTRL, 8'hC8);
			reg_rd(ADDR_CTRL, d);
			check(d, 8'hC8);
			reg_wr(ADDR_SELECT, sel ^ 8'hDF);
			@(posedge mclk);
			#1 check({3'h0, core_channel}, ch[7:0]);
			check({6'h00, core_ref}, (rf == 2) ? 8'h00 : rf[7:0]);
			check({7'h00, core_diff}, {7'h00, df});
			check({7'h00, core_run}, 8'h01);
			check({7'h00, core_first}, {7'h00, i == 0});
			wait_done();
			check(d, 8'h98);
			check({7'h00, irq_request}, 8'h01);
			// Divide by two: one converter clock every two cycles
			check(8'(conv_cyc), (i == 0) ? 8'h32 : 8'h1A);
			check({7'h00, core_run}, 8'h00);
			// The selection written mid-run reaches the core only now
			check({3'h0, core_channel}, 8'(ch ^ 31));
			rf = rf ^ 3;
			check({6'h00, core_ref}, (rf == 2) ? 8'h00 : rf[7:0]);
			read_pair(expect_pair(df, lvl_t[i], i[0]));
			reg_wr(ADDR_SELECT, sel ^ 8'h20);
			exp16 = expect_pair(df, lvl_t[i], !i[0]);
			read_pair(exp16);
			if (i[0])
				reg_wr(ADDR_CTRL, 8'h98);
			else begin
				@(posedge mclk);
				irq_ack <= 1'b1;
				@(posedge mclk);
				irq_ack <= 1'b0;
			end
			reg_rd(ADDR_CTRL, d);
			check(d, 8'h88);
		end
		// Disable in mid-conversion; a new level exposes a leaked result
		level <= 11'h0AA;
		reg_wr(ADDR_CTRL, 8'hC0);
		repeat (6) @(posedge mclk);
		reg_wr(ADDR_CTRL, 8'h00);
		repeat (80) @(posedge mclk);
		reg_rd(ADDR_CTRL, d);
		check(d, 8'h00);
		check({7'h00, core_power}, 8'h00);
		read_pair(exp16);
		// Low read locks the pair against a new result
		level <= 11'h155;
		reg_rd(ADDR_RESULT_LOW, lo);
		check(lo, exp16[7:0]);
		reg_wr(ADDR_CTRL, 8'hC0);
		wait_done();
		check(d, 8'h90);
		check(8'(conv_cyc), 8'h32);
		check({7'h00, irq_request}, 8'h00);
		reg_rd(ADDR_RESULT_HIGH, hi);
		check(hi, exp16[15:8]);
		reg_rd(ADDR_RESULT_LOW, lo);
		check(lo, exp16[7:0]);
		stop_test();
	end
endmodule
